// ==== include/acw_pkg.sv ====
package acw_pkg;

  // Command byte layout.
  localparam int unsigned CMD_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 24;
  localparam int unsigned CMD_DEV_LSB = 6;
  localparam int unsigned CMD_ADR_LSB = 2;
  localparam int unsigned CMD_TYP_LSB = 0;

  // Command types.
  localparam logic [1:0] TYPE_QUICK = 2'h0;
  localparam logic [1:0] TYPE_IWRITE = 2'h2;

  // Quick command codes.
  localparam logic [3:0] QC_START = 4'hA;
  localparam logic [3:0] QC_STANDBY = 4'hB;
  localparam logic [3:0] QC_ADC_OFF = 4'hC;
  localparam logic [3:0] QC_FULL_OFF = 4'hD;
  localparam logic [3:0] QC_FULL_RESET = 4'hE;

  // Conversion mode field values and full shutdown value.
  localparam logic [1:0] MODE_CONVERT = 2'h3;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_ADC_OFF = 2'h0;
  localparam logic [7:0] CFG0_FULL_OFF = 8'h00;

  // Register map positions.
  localparam logic [3:0] ADDR_RESULT = 4'h0;
  localparam logic [3:0] ADDR_LAST = 4'hF;
  localparam logic [3:0] ADDR_WR_FIRST = 4'h1;
  localparam logic [3:0] ADDR_WR_LAST = 4'hD;
  localparam logic [3:0] ADDR_CFG0 = 4'h1;
  localparam logic [3:0] ADDR_IRQ = 4'h5;
  localparam int unsigned CFG0_MODE_LSB = 0;
  localparam int unsigned IRQ_QEN_BIT = 0;

  // Status byte and bit counting.
  localparam logic [3:0] CNT_ADDR_DONE = 4'h1;
  localparam logic [3:0] CNT_CMD_LAST = 4'h7;
  localparam logic [3:0] CNT_CMD_DONE = 4'h8;

  typedef struct packed {
    logic dr;
    logic crc;
    logic por;
  } acw_flags_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } acw_wr_s;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_WRITE,
    PH_IGNORE
  } acw_phase_e;

  // Register lengths in bits minus one.
  function automatic logic [4:0] reg_last_bit(input logic [3:0] addr);
    logic [4:0] r;
    r = 5'h07;
    if (addr == ADDR_RESULT || (addr >= 4'h8 && addr <= 4'hA)) begin
      r = 5'h17;
    end else if (addr >= 4'hE) begin
      r = 5'h0F;
    end
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] reg_default(input logic [3:0] addr);
    logic [DATA_W-1:0] r;
    r = 24'h00_0000;
    if (addr == ADDR_IRQ) begin
      r = 24'h00_0001;
    end
    return r;
  endfunction

endpackage

// ==== rtl/acw_sync.sv ====
module acw_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule

// ==== rtl/acw_cmd_front.sv ====
module acw_cmd_front #(
  parameter logic [1:0] BUILT_IN_DEVICE_ADDRESS = 2'h1
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_SCK,
  input wire logic I_CS_N,
  input wire logic I_SDI,
  input wire logic I_DATA_READY,
  input wire logic I_CRC_ERROR,
  output logic O_SDO,
  output logic O_SDO_OE,
  output logic O_WR_STROBE,
  output logic [acw_pkg::ADDR_W-1:0] O_WR_ADDR,
  output logic [acw_pkg::DATA_W-1:0] O_WR_DATA,
  output logic [7:0] O_FIRST_CONFIGURATION_REGISTER,
  output logic O_QUICK_EN,
  output logic O_POR_FLAG,
  output logic O_DEVICE_RESET
);

  // Link side, clocked by the serial clock and cleared by each frame end.
  logic [3:0] cnt;
  logic [acw_pkg::CMD_W-1:0] cmd;
  logic [acw_pkg::CMD_W-1:0] next_cmd;
  logic matched;
  logic [7:0] stat;
  acw_pkg::acw_phase_e phase;
  logic [acw_pkg::ADDR_W-1:0] ptr;
  logic blocked;
  logic [4:0] bit_cnt;
  logic [acw_pkg::DATA_W-1:0] dat;
  logic [acw_pkg::DATA_W-1:0] next_dat;
  logic reg_done;
  logic sdo_drive;
  logic sdo_bit;

  // Link side event toggles and their held payloads.
  logic link_rst;
  logic wr_tgl;
  logic qc_tgl;
  logic st_tgl;
  acw_pkg::acw_wr_s wr_hold;
  logic [3:0] qc_code;

  // System side.
  logic [3:0] sync_out;
  logic cs_idle;
  logic wr_seen;
  logic qc_seen;
  logic st_seen;
  logic wr_ev;
  logic qc_ev;
  logic st_ev;
  acw_pkg::acw_flags_s flags;
  acw_pkg::acw_flags_s snap;
  acw_pkg::acw_flags_s late;
  logic por_set;
  // The whole map sits here so that a full reset restores every word in one cycle.
  logic [acw_pkg::DATA_W-1:0] regs [16];

  assign next_cmd = {cmd[acw_pkg::CMD_W-2:0], I_SDI};
  assign next_dat = {dat[acw_pkg::DATA_W-2:0], I_SDI};
  assign reg_done = (phase == acw_pkg::PH_WRITE) && (bit_cnt == acw_pkg::reg_last_bit(ptr));

  // Chip select high clears all frame state, so every frame begins with a command byte.
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      cnt <= 4'h0;
      cmd <= 8'h00;
    end else if (cnt != acw_pkg::CNT_CMD_DONE) begin
      cnt <= cnt + 4'h1;
      cmd <= next_cmd;
    end
  end

  // The snapshot is taken on the edge that completes the address field.
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      matched <= 1'b0;
      stat <= 8'h00;
    end else if (cnt == acw_pkg::CNT_ADDR_DONE) begin
      matched <= (next_cmd[1:0] == BUILT_IN_DEVICE_ADDRESS);
      stat <= {2'b00, BUILT_IN_DEVICE_ADDRESS, ~BUILT_IN_DEVICE_ADDRESS[0],
               snap.dr, snap.crc, snap.por};
    end
  end

  // The command type is fixed for the whole frame once the byte is in.
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      phase <= acw_pkg::PH_CMD;
      ptr <= 4'h0;
      blocked <= 1'b0;
    end else if (cnt == acw_pkg::CNT_CMD_LAST) begin
      if (matched && next_cmd[1:0] == acw_pkg::TYPE_IWRITE) begin
        phase <= acw_pkg::PH_WRITE;
        ptr <= next_cmd[acw_pkg::CMD_ADR_LSB +: acw_pkg::ADDR_W];
        blocked <= (next_cmd[5:2] == acw_pkg::ADDR_RESULT) ||
                   (next_cmd[5:2] == acw_pkg::ADDR_LAST);
      end else begin
        phase <= acw_pkg::PH_IGNORE;
      end
    end else if (reg_done && !blocked) begin
      if (ptr == acw_pkg::ADDR_WR_LAST) begin
        ptr <= acw_pkg::ADDR_WR_FIRST;
      end else begin
        ptr <= ptr + 4'h1;
      end
    end
  end

  // Data bits of the register being written; a frame end discards a partial word.
  always_ff @(posedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      bit_cnt <= 5'h00;
      dat <= 24'h00_0000;
    end else if (phase == acw_pkg::PH_WRITE) begin
      // Emptied per register, so a short word never carries bits of the one before.
      if (reg_done) begin
        bit_cnt <= 5'h00;
        dat <= 24'h00_0000;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
        dat <= next_dat;
      end
    end
  end

  // Output changes on the falling edge so the host samples it on the rising one.
  always_ff @(negedge I_SCK or posedge I_CS_N) begin
    if (I_CS_N) begin
      sdo_bit <= 1'b0;
      sdo_drive <= 1'b1;
    end else begin
      if (cnt > acw_pkg::CNT_ADDR_DONE && cnt < acw_pkg::CNT_CMD_DONE) begin
        sdo_bit <= stat[3'(acw_pkg::CNT_CMD_LAST - cnt)];
      end else begin
        sdo_bit <= 1'b0;
      end
      // Reads are not served here, so every command floats after its status byte.
      sdo_drive <= (cnt <= acw_pkg::CNT_ADDR_DONE) ||
                   (matched && cnt < acw_pkg::CNT_CMD_DONE);
    end
  end

  assign O_SDO = sdo_bit;
  // Gated with chip select so the pin can float between frames without a serial clock edge.
  assign O_SDO_OE = sdo_drive && !I_CS_N;

  // Event toggles live across frames, so they take the system reset instead.
  // One stage is enough: the link side has no serial clock while the system reset ends.
  always_ff @(posedge I_MCLK) begin
    link_rst <= I_RST;
  end

  always_ff @(posedge I_SCK or posedge link_rst) begin
    if (link_rst) begin
      st_tgl <= 1'b0;
      qc_tgl <= 1'b0;
      qc_code <= 4'h0;
    end else if (cnt == acw_pkg::CNT_CMD_LAST && matched) begin
      st_tgl <= ~st_tgl;
      if (next_cmd[1:0] == acw_pkg::TYPE_QUICK) begin
        qc_tgl <= ~qc_tgl;
        qc_code <= next_cmd[acw_pkg::CMD_ADR_LSB +: acw_pkg::ADDR_W];
      end
    end
  end

  // The payload holds still for a whole register, far longer than the crossing takes.
  always_ff @(posedge I_SCK or posedge link_rst) begin
    if (link_rst) begin
      wr_tgl <= 1'b0;
      wr_hold <= '0;
    end else if (reg_done && !blocked) begin
      wr_tgl <= ~wr_tgl;
      wr_hold <= '{addr: ptr, data: next_dat};
    end
  end

  acw_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk(I_MCLK),
    .i_rst(I_RST),
    .i_async({I_CS_N, wr_tgl, qc_tgl, st_tgl}),
    .o_sync(sync_out)
  );

  assign cs_idle = sync_out[3];
  assign wr_ev = sync_out[2] ^ wr_seen;
  assign qc_ev = sync_out[1] ^ qc_seen;
  assign st_ev = sync_out[0] ^ st_seen;

  // One condition for every effect of a full reset keeps the flag, pulse and map in step.
  assign por_set = qc_ev && regs[acw_pkg::ADDR_IRQ][acw_pkg::IRQ_QEN_BIT] &&
                   (qc_code == acw_pkg::QC_FULL_RESET);

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      wr_seen <= 1'b0;
      qc_seen <= 1'b0;
      st_seen <= 1'b0;
    end else begin
      wr_seen <= sync_out[2];
      qc_seen <= sync_out[1];
      st_seen <= sync_out[0];
    end
  end

  // Sticky status flags; a new event wins over the clear in the same cycle.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      flags <= '0;
    end else begin
      flags.dr <= I_DATA_READY ||
                  (flags.dr && !(st_ev && snap.dr && !late.dr));
      flags.crc <= I_CRC_ERROR ||
                   (flags.crc && !(st_ev && snap.crc && !late.crc));
      flags.por <= por_set ||
                   (flags.por && !(st_ev && snap.por && !late.por));
    end
  end

  // A flag that fires again after the snapshot froze was not in this frame's status byte,
  // so the clear at the end of that byte must leave it standing.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      late <= '0;
    end else if (cs_idle) begin
      late <= '0;
    end else begin
      late.dr <= late.dr || I_DATA_READY;
      late.crc <= late.crc || I_CRC_ERROR;
      late.por <= late.por || por_set;
    end
  end

  // Frozen while a frame runs, so events after capture wait for the next frame.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      snap <= '0;
    end else if (cs_idle) begin
      snap <= flags;
    end
  end

  // Writable register map and quick command execution.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      for (int i = 0; i < 16; i++) begin
        regs[i] <= acw_pkg::reg_default(4'(i));
      end
    end else if (qc_ev && regs[acw_pkg::ADDR_IRQ][acw_pkg::IRQ_QEN_BIT]) begin
      case (qc_code)
        acw_pkg::QC_START: begin
          regs[acw_pkg::ADDR_CFG0][acw_pkg::CFG0_MODE_LSB +: 2] <= acw_pkg::MODE_CONVERT;
        end
        acw_pkg::QC_STANDBY: begin
          regs[acw_pkg::ADDR_CFG0][acw_pkg::CFG0_MODE_LSB +: 2] <= acw_pkg::MODE_STANDBY;
        end
        acw_pkg::QC_ADC_OFF: begin
          regs[acw_pkg::ADDR_CFG0][acw_pkg::CFG0_MODE_LSB +: 2] <= acw_pkg::MODE_ADC_OFF;
        end
        acw_pkg::QC_FULL_OFF: begin
          regs[acw_pkg::ADDR_CFG0][7:0] <= acw_pkg::CFG0_FULL_OFF;
        end
        acw_pkg::QC_FULL_RESET: begin
          for (int i = 0; i < 16; i++) begin
            regs[i] <= acw_pkg::reg_default(4'(i));
          end
        end
        default: begin
        end
      endcase
    end else if (wr_ev) begin
      regs[wr_hold.addr] <= wr_hold.data;
    end
  end

  // Write strobe to the rest of the converter, one cycle per register, none when a quick command event lands in the same cycle.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_WR_STROBE <= 1'b0;
      O_WR_ADDR <= 4'h0;
      O_WR_DATA <= 24'h00_0000;
    end else begin
      O_WR_STROBE <= wr_ev && !qc_ev;
      if (wr_ev) begin
        O_WR_ADDR <= wr_hold.addr;
        O_WR_DATA <= wr_hold.data;
      end
    end
  end

  // Full reset pulse lets the rest of the device clear its read-only state too.
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_DEVICE_RESET <= 1'b0;
      O_POR_FLAG <= 1'b0;
    end else begin
      O_DEVICE_RESET <= por_set;
      if (por_set) begin
        O_POR_FLAG <= 1'b1;
      end
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      O_FIRST_CONFIGURATION_REGISTER <= 8'h00;
      O_QUICK_EN <= 1'b1;
    end else begin
      O_FIRST_CONFIGURATION_REGISTER <= regs[acw_pkg::ADDR_CFG0][7:0];
      O_QUICK_EN <= regs[acw_pkg::ADDR_IRQ][acw_pkg::IRQ_QEN_BIT];
    end
  end

endmodule

// ==== tb/acw_cmd_front_monitor.sv ====
module acw_cmd_front_monitor (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic I_CS_N,
  input wire logic O_SDO,
  input wire logic O_SDO_OE,
  input wire logic O_WR_STROBE,
  input wire logic [acw_pkg::ADDR_W-1:0] O_WR_ADDR,
  input wire logic [acw_pkg::DATA_W-1:0] O_WR_DATA,
  input wire logic [7:0] O_FIRST_CONFIGURATION_REGISTER,
  input wire logic O_QUICK_EN,
  input wire logic O_POR_FLAG,
  input wire logic O_DEVICE_RESET
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (I_RST);
  idle_float_a: assert property (I_CS_N |-> !O_SDO_OE && !O_SDO)
    else $error("output active while deselected");
  cs_fall_zero_a: assert property ($fell(I_CS_N) |-> O_SDO_OE && !O_SDO)
    else $error("output not driven low at select");
  strobe_once_a: assert property (O_WR_STROBE |=> !O_WR_STROBE)
    else $error("write strobe longer than one cycle");
  wr_target_a: assert property (O_WR_STROBE |-> O_WR_ADDR >= 4'h1 && O_WR_ADDR <= 4'hD)
    else $error("write to read-only address");
  cfg0_write_a: assert property (O_WR_STROBE && O_WR_ADDR == 4'h1
    |-> ##[0:3] O_FIRST_CONFIGURATION_REGISTER == O_WR_DATA[7:0]) else $error("first_configuration_register not written");
  quick_en_write_a: assert property (O_WR_STROBE && O_WR_ADDR == 4'h5
    |-> ##[0:3] O_QUICK_EN == O_WR_DATA[0]) else $error("quick enable not written");
  full_reset_a: assert property (O_DEVICE_RESET |-> ##[0:3]
    (O_POR_FLAG && O_QUICK_EN && O_FIRST_CONFIGURATION_REGISTER == 8'h00)) else $error("full reset incomplete");
  devrst_pulse_a: assert property (O_DEVICE_RESET |=> !O_DEVICE_RESET)
    else $error("device reset longer than one cycle");
  por_sticky_a: assert property (!$fell(O_POR_FLAG))
    else $error("power-on flag cleared without reset");
endmodule

bind acw_cmd_front acw_cmd_front_monitor u_mon (.I_MCLK(I_MCLK), .I_RST(I_RST),
  .I_CS_N(I_CS_N), .O_SDO(O_SDO), .O_SDO_OE(O_SDO_OE), .O_WR_STROBE(O_WR_STROBE),
  .O_WR_ADDR(O_WR_ADDR), .O_WR_DATA(O_WR_DATA), .O_FIRST_CONFIGURATION_REGISTER(O_FIRST_CONFIGURATION_REGISTER),
  .O_QUICK_EN(O_QUICK_EN), .O_POR_FLAG(O_POR_FLAG), .O_DEVICE_RESET(O_DEVICE_RESET));

// ==== tb/acw_host.sv ====
module acw_host (
  input wire logic i_ref,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_sdi
);
  timeunit 1ns;
  timeprecision 1ns;
  logic line;
  // Nothing pulls the shared line, so a silent device reads as z.
  assign line = i_sdo_oe ? i_sdo : 1'bz;
  initial begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end
  // The odd offset keeps serial edges away from system clock edges.
  task automatic xfer(input logic [31:0] d, input int n, output logic [7:0] st,
                      output logic oe);
    @(negedge i_ref);
    #37;
    o_cs_n = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      o_sdi = d[n-1-i];
      #80;
      o_sck = 1'b1;
      if (i < 8) st[7-i] = line;
      #80;
      o_sck = 1'b0;
    end
    #40;
    oe = i_sdo_oe;
    #40;
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #600;
  endtask
endmodule

// ==== tb/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] DA = 2'h1;
  logic I_MCLK, I_RST, I_DATA_READY, I_CRC_ERROR, sck, cs_n, sdi;
  logic sdo, sdo_oe, wr_stb, qen, por, dev_rst, oe_end;
  logic [3:0] wr_addr;
  logic [23:0] wr_data;
  logic [7:0] cfg0, st;
  logic [27:0] wq[$];
  int fail_count = 0;
  int check_count = 0;
  int rst_count = 0;

  acw_cmd_front #(.BUILT_IN_DEVICE_ADDRESS(DA)) dut (.I_MCLK(I_MCLK), .I_RST(I_RST),
    .I_SCK(sck), .I_CS_N(cs_n), .I_SDI(sdi), .I_DATA_READY(I_DATA_READY),
    .I_CRC_ERROR(I_CRC_ERROR), .O_SDO(sdo), .O_SDO_OE(sdo_oe), .O_WR_STROBE(wr_stb),
    .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data), .O_FIRST_CONFIGURATION_REGISTER(cfg0), .O_QUICK_EN(qen),
    .O_POR_FLAG(por), .O_DEVICE_RESET(dev_rst));
  acw_host host (.i_ref(I_MCLK), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sck(sck),
    .o_cs_n(cs_n), .o_sdi(sdi));

  initial begin
    I_MCLK = 1'b0;
    forever #50 I_MCLK = ~I_MCLK;
  end

  always @(posedge I_MCLK) begin
    if (wr_stb === 1'b1) wq.push_back({wr_addr, wr_data});
    if (dev_rst === 1'b1) rst_count <= rst_count + 1;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic qk(input logic [1:0] a, input logic [3:0] c);
    host.xfer({a, c, 2'h0}, 8, st, oe_end);
  endtask

  task automatic wr8(input logic [3:0] a, input logic [7:0] v);
    host.xfer({DA, a, 2'h2, v}, 16, st, oe_end);
  endtask

  task automatic do_reset;
    I_RST <= 1'b1;
    repeat (12) @(posedge I_MCLK);
    I_RST <= 1'b0;
    repeat (4) @(posedge I_MCLK);
    chk("first_configuration_register", 8'h00, cfg0);
    chk("quick_en", 1, qen);
    chk("por", 0, por);
  endtask

  task automatic t_status;
    @(posedge I_MCLK);
    I_DATA_READY <= 1'b1;
    I_CRC_ERROR <= 1'b1;
    @(posedge I_MCLK);
    I_DATA_READY <= 1'b0;
    I_CRC_ERROR <= 1'b0;
    fork
      qk(DA, 4'h3);
      begin
        // Lands after the status byte was captured, so it belongs to the next frame.
        repeat (10) @(posedge I_MCLK);
        I_DATA_READY <= 1'b1;
        @(posedge I_MCLK);
        I_DATA_READY <= 1'b0;
      end
    join
    chk("status", {2'h0, DA, ~DA[0], 3'h6}, st);
    chk("oe_quick", 0, oe_end);
    qk(DA, 4'hF);
    chk("status_late", {2'h0, DA, ~DA[0], 3'h4}, st);
    qk(DA, 4'hF);
    chk("status_clr", {2'h0, DA, ~DA[0], 3'h0}, st);
    chk("first_configuration_register_undef", 8'h00, cfg0);
  endtask

  task automatic t_quick;
    logic [7:0] ex[3] = '{8'hFF, 8'hFE, 8'hFC};
    wr8(4'h1, 8'hFC);
    for (int i = 0; i < 3; i++) begin
      qk(DA, 4'hA + i[3:0]);
      chk("mode", ex[i], cfg0);
    end
    qk(DA, 4'hD);
    chk("full_off", 8'h00, cfg0);
  endtask

  task automatic t_write;
    int b;
    b = wq.size();
    host.xfer({DA, 4'hD, 2'h2, 24'h5A_6677}, 32, st, oe_end);
    chk("strobes", b + 3, wq.size());
    chk("wr0", {4'hD, 24'h00_005A}, wq[b]);
    chk("wr1", {4'h1, 24'h00_0066}, wq[b + 1]);
    chk("wr2", {4'h2, 24'h00_0077}, wq[b + 2]);
    chk("oe_write", 0, oe_end);
    host.xfer({DA, 4'h1, 2'h2, 4'h3}, 12, st, oe_end);
    host.xfer({DA, 4'h0, 2'h2, 24'h12_3456}, 32, st, oe_end);
    host.xfer({DA, 4'hF, 2'h2, 16'h1234}, 24, st, oe_end);
    chk("no_strobe", b + 3, wq.size());
    chk("first_configuration_register_kept", 8'h66, cfg0);
  endtask

  task automatic t_gate;
    wr8(4'h5, 8'h00);
    chk("quick_off", 0, qen);
    qk(DA, 4'hA);
    chk("first_configuration_register_held", 8'h66, cfg0);
    wr8(4'h5, 8'h01);
    chk("quick_on", 1, qen);
    qk(DA ^ 2'h3, 4'hA);
    chk("status_float", {2'h0, {6{1'bz}}}, st);
    chk("first_configuration_register_mis", 8'h66, cfg0);
    chk("oe_mis", 0, oe_end);
  endtask

  task automatic t_full_reset;
    int n;
    wr8(4'h1, 8'h33);
    n = rst_count;
    qk(DA, 4'hE);
    chk("dev_reset", n + 1, rst_count);
    chk("first_configuration_register_def", 8'h00, cfg0);
    chk("por_set", 1, por);
    qk(DA, 4'h0);
    chk("status_por", {2'h0, DA, ~DA[0], 3'h1}, st);
  endtask

  initial begin
    I_RST = 1'b1;
    I_DATA_READY = 1'b0;
    I_CRC_ERROR = 1'b0;
    do_reset();
    t_status();
    t_quick();
    t_write();
    t_gate();
    t_full_reset();
    do_reset();
    test_done();
  end

  initial begin
    #1_000_000;
    fail_count++;
    test_done();
  end
endmodule
